/* File: rtl/ptmr_pkg.sv */
// Package: register map, field layout, modes and carriers of the periodic timer
package ptmr_pkg;
  localparam int CNT_W = 10;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_PERIOD = 12'h004;
  localparam logic [11:0] OFS_DUTY = 12'h008;
  localparam logic [11:0] OFS_COUNT = 12'h00C;
  localparam logic [11:0] OFS_FLAGS = 12'h010;
  localparam int CTRL_RUN_POS = 8;
  localparam int FLAG_DUTY_POS = 0;
  localparam int FLAG_PERIOD_POS = 1;
  localparam logic [9:0] RST_COUNT = 10'h000;
  localparam logic [9:0] RST_COMPARE = 10'h000;
  localparam logic [1:0] SEL_CAPTURE = 2'h1;
  localparam logic [1:0] SEL_WAVE = 2'h2;
  localparam logic [1:0] PIN_FORCE_LO = 2'h0;
  localparam logic [1:0] PIN_FORCE_HI = 2'h1;
  localparam logic [1:0] PIN_PWM = 2'h2;
  localparam logic [1:0] PIN_PULSE = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register bits 7..0
  typedef struct packed {
    logic [1:0] mode_select;
    logic [1:0] pin_function;
    logic output_control_bit;
    logic polarity_invert_bit;
    logic counter_clear_select;
    logic capture_source_select;
  } ptmr_ctrl_s;
  localparam ptmr_ctrl_s RST_CTRL = '0;

  typedef enum logic [3:0] {
    MODE_PWM = 4'h1,
    MODE_PULSE = 4'h2,
    MODE_CAPTURE = 4'h4,
    MODE_OTHER = 4'h8
  } ptmr_mode_e;
endpackage

/* File: rtl/ptmr_top.sv */
// Periodic 10-bit timer with PWM, single pulse and capture modes, AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Mode field 10 with pin field 10 selects PWM output.
// - PWM: period value clears counter, duty value sets active part.
// - PWM: counter-clear select ignored; period match always clears.
// - PWM: separate flags for duty match and period match.
// - PWM: output control picks active level, polarity bit inverts pin.
// - PWM: pin field enables waveform or forces pin low or high.
// - PWM: with pin field 00 or 01 counter and compares keep running.
// - Period zero gives 1024 clocks, else period equals value.
// - Duty at or above period gives 100 percent active output.
// - Mode 10 with pin field 11 selects single pulse mode.
// - Single pulse: run bit rising starts counter, pulse leading edge.
// - Single pulse: trigger pin rising edge sets run bit itself.
// - Single pulse: duty match or software clears run, ending pulse.
// - Single pulse: counter returns to zero only on run rising.
// - Single pulse: period value and clear select are ignored.
// - Mode 01 selects capture; counter starts on run bit rising.
// - Capture: source select picks capture pin or trigger pin.
// - Capture: pin field picks rise, fall, both; 11 captures nothing.
// - Capture edge copies counter into duty value and raises flag.
// - Capture: counter runs regardless of pin until run falls.
// - Capture: period match clears counter, raises flag; zero means full range.
// - Capture: clear select, output control, polarity unused; no output.
// - Capture source select 0 is capture pin, 1 trigger pin.
// - Output control 0 is active low, 1 active high.
// - Counter and both compare values are 10 bits wide.
module ptmr_top
  import ptmr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_trigger_pin,
  input wire logic capture_input_pin,
  output logic timer_out_pin,
  output logic duty_match_flag,
  output logic period_match_flag
);

  function automatic ptmr_mode_e decode_mode(input ptmr_ctrl_s c);
    if (c.mode_select == SEL_CAPTURE) begin
      decode_mode = MODE_CAPTURE;
    end else if (c.mode_select == SEL_WAVE && c.pin_function == PIN_PULSE) begin
      decode_mode = MODE_PULSE;
    end else if (c.mode_select == SEL_WAVE) begin
      decode_mode = MODE_PWM;
    end else begin
      decode_mode = MODE_OTHER;
    end
  endfunction

  // Byte-lane merge of a write into a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ptmr_ctrl_s ctrl;
  logic counter_run_bit;
  logic run_q;
  logic [9:0] period_compare_value;
  logic [9:0] duty_compare_value;
  logic [9:0] count;
  logic trig_q;
  logic cap_q;
  ptmr_mode_e mode;
  logic run_rise;
  logic period_hit;
  logic duty_hit;
  logic trig_rise;
  logic cap_src;
  logic cap_src_q;
  logic cap_edge;
  logic wave_active;
  logic next_out;
  logic wr_go;
  logic rd_go;
  logic wr_ctrl;
  logic wr_flags;
  logic [15:0] ctrl_merged;
  logic [15:0] period_merged;
  logic [15:0] duty_merged;

  assign mode = decode_mode(ctrl);
  assign run_rise = counter_run_bit && !run_q;
  // Zero period wraps at 1023, giving 1024 clocks
  // A stale count in the restart cycle must not match
  assign period_hit = counter_run_bit && !run_rise &&
                      (count == period_compare_value - 10'h001);
  assign duty_hit = counter_run_bit && !run_rise && (count == duty_compare_value);
  assign trig_rise = external_trigger_pin && !trig_q;
  assign cap_src = ctrl.capture_source_select ? external_trigger_pin : capture_input_pin;
  assign cap_src_q = ctrl.capture_source_select ? trig_q : cap_q;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign wr_ctrl = wr_go && s_axi_awaddr == OFS_CTRL;
  assign wr_flags = wr_go && s_axi_awaddr == OFS_FLAGS;
  assign ctrl_merged = merge16({7'h00, counter_run_bit, ctrl}, s_axi_wdata, s_axi_wstrb);
  assign period_merged = merge16({6'h00, period_compare_value}, s_axi_wdata, s_axi_wstrb);
  assign duty_merged = merge16({6'h00, duty_compare_value}, s_axi_wdata, s_axi_wstrb);

  always_comb begin
    case (ctrl.pin_function)
      EDGE_RISE: cap_edge = cap_src && !cap_src_q;
      EDGE_FALL: cap_edge = !cap_src && cap_src_q;
      EDGE_BOTH: cap_edge = cap_src != cap_src_q;
      default: cap_edge = 1'b0;
    endcase
  end

  // Active part of the PWM period; full duty when duty reaches the period
  always_comb begin
    wave_active = ({1'b0, duty_compare_value} >=
                   {period_compare_value == 10'h000, period_compare_value}) ||
                  (count < duty_compare_value);
  end

  always_comb begin
    case (mode)
      MODE_PWM: begin
        case (ctrl.pin_function)
          PIN_FORCE_LO: next_out = 1'b0;
          PIN_FORCE_HI: next_out = 1'b1;
          default: next_out = (ctrl.output_control_bit ? wave_active : !wave_active)
                              ^ ctrl.polarity_invert_bit;
        endcase
      end
      MODE_PULSE: next_out = (ctrl.output_control_bit ? counter_run_bit : !counter_run_bit)
                             ^ ctrl.polarity_invert_bit;
      MODE_CAPTURE: next_out = 1'b0;
      default: next_out = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_q <= 1'b0;
      cap_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      trig_q <= external_trigger_pin;
      cap_q <= capture_input_pin;
      run_q <= counter_run_bit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= ctrl_merged[7:0];
    end
  end

  // Hardware set by trigger wins over a simultaneous software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_run_bit <= 1'b0;
    end else if (mode == MODE_PULSE && trig_rise) begin
      counter_run_bit <= 1'b1;
    end else if (wr_ctrl) begin
      counter_run_bit <= ctrl_merged[CTRL_RUN_POS];
    end else if (mode == MODE_PULSE && duty_hit) begin
      counter_run_bit <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= RST_COUNT;
    end else if (run_rise) begin
      count <= RST_COUNT;
    end else if (counter_run_bit) begin
      if (mode != MODE_PULSE && period_hit) begin
        count <= RST_COUNT;
      end else begin
        count <= count + 10'h001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_compare_value <= RST_COMPARE;
    end else if (wr_go && s_axi_awaddr == OFS_PERIOD) begin
      period_compare_value <= period_merged[9:0];
    end
  end

  // Capture takes precedence over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_compare_value <= RST_COMPARE;
    end else if (mode == MODE_CAPTURE && counter_run_bit && cap_edge) begin
      duty_compare_value <= count;
    end else if (wr_go && s_axi_awaddr == OFS_DUTY) begin
      duty_compare_value <= duty_merged[9:0];
    end
  end

  // Sticky flags, write one to clear, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_match_flag <= 1'b0;
    end else if ((mode == MODE_CAPTURE) ? (counter_run_bit && cap_edge)
                                        : (mode != MODE_OTHER && duty_hit)) begin
      duty_match_flag <= 1'b1;
    end else if (wr_flags && s_axi_wstrb[0] && s_axi_wdata[FLAG_DUTY_POS]) begin
      duty_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_match_flag <= 1'b0;
    end else if ((mode == MODE_PWM || mode == MODE_CAPTURE) && period_hit) begin
      period_match_flag <= 1'b1;
    end else if (wr_flags && s_axi_wstrb[0] && s_axi_wdata[FLAG_PERIOD_POS]) begin
      period_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_out_pin <= 1'b0;
    end else begin
      timer_out_pin <= next_out;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go && !s_axi_awready;
      s_axi_wready <= wr_go && !s_axi_awready;
      if (wr_go && !s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        case (s_axi_awaddr)
          OFS_CTRL, OFS_PERIOD, OFS_DUTY, OFS_COUNT, OFS_FLAGS: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go && !s_axi_arready;
      if (rd_go && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          OFS_CTRL: s_axi_rdata <= {23'h000000, counter_run_bit, ctrl};
          OFS_PERIOD: s_axi_rdata <= {22'h000000, period_compare_value};
          OFS_DUTY: s_axi_rdata <= {22'h000000, duty_compare_value};
          OFS_COUNT: s_axi_rdata <= {22'h000000, count};
          OFS_FLAGS: s_axi_rdata <= {30'h00000000, period_match_flag, duty_match_flag};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_pwm_period_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PWM && counter_run_bit && !run_rise && period_hit && !wr_ctrl)
      |=> count == 10'h000 && period_match_flag)
    else $error("pwm counter not cleared on period match");

  a_full_period: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PWM && counter_run_bit && !run_rise && period_compare_value == 10'h000 &&
     count == 10'h3FF) |=> count == 10'h000 && period_match_flag)
    else $error("zero period did not wrap after 1024 clocks");

  a_pwm_full_duty: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PWM && ctrl.pin_function == PIN_PWM && !ctrl.polarity_invert_bit &&
     ctrl.output_control_bit && duty_compare_value >= period_compare_value &&
     period_compare_value != 10'h000) |=> timer_out_pin)
    else $error("full duty output not active");

  a_pin_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PWM && ctrl.pin_function == PIN_FORCE_HI) |=> timer_out_pin)
    else $error("forced high pin not high");

  a_pulse_trigger: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PULSE && trig_rise) |=> counter_run_bit)
    else $error("trigger edge did not set run");

  a_pulse_end: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PULSE && duty_hit && !trig_rise && !wr_ctrl)
      |=> !counter_run_bit && duty_match_flag)
    else $error("duty match did not end pulse");

  a_run_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    run_rise |=> count == 10'h000 || (counter_run_bit && count == 10'h001))
    else $error("counter not restarted from zero");

  a_capture_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_CAPTURE && counter_run_bit && cap_edge)
      |=> duty_compare_value == $past(count) && duty_match_flag)
    else $error("capture did not load counter value");

  a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!counter_run_bit && !run_rise) |=> count == $past(count))
    else $error("counter moved while stopped");

  a_capture_no_out: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == MODE_CAPTURE |=> !timer_out_pin)
    else $error("output driven in capture mode");

  a_pwm_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PWM && duty_hit) |=> duty_match_flag)
    else $error("duty match flag not raised");

  a_pulse_period_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PULSE && !period_match_flag) |=> !period_match_flag)
    else $error("period flag raised in single pulse mode");

  a_pulse_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PULSE && counter_run_bit && !run_rise)
      |=> count == $past(count) + 10'h001)
    else $error("pulse counter did not advance");

  a_capture_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_CAPTURE && counter_run_bit && !run_rise && !period_hit)
      |=> count == $past(count) + 10'h001)
    else $error("capture counter did not free run");

  a_capture_period: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_CAPTURE && period_hit)
      |=> count == 10'h000 && period_match_flag)
    else $error("capture period match not handled");

  a_capture_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_CAPTURE && ctrl.pin_function == 2'h3 &&
     !(wr_go && s_axi_awaddr == OFS_DUTY))
      |=> duty_compare_value == $past(duty_compare_value))
    else $error("capture taken with edge select off");

endmodule

`default_nettype wire

/* File: tb/ptmr_pins.sv */
// Far-side pin model: trigger and capture input pins
`timescale 1ns/10ps
`default_nettype none
module ptmr_pins (
  input wire logic aclk,
  output logic trig,
  output logic cap
);
  initial begin
    trig = 1'b0;
    cap = 1'b0;
  end
  // Moves one pin just after a clock edge
  task automatic set_pin(input logic sel, input logic lvl);
    @(posedge aclk);
    if (sel) trig <= lvl;
    else cap <= lvl;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the periodic timer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ptmr_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tout, dflag, pflag, trig, cap;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, v2;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  logic [34:0] expq[$];
  logic [34:0] e;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int hi, ri;

  ptmr_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .external_trigger_pin(trig), .capture_input_pin(cap),
    .timer_out_pin(tout), .duty_match_flag(dflag), .period_match_flag(pflag));
  ptmr_pins u_pins (.aclk(aclk), .trig(trig), .cap(cap));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Oldest note is checked at each response handshake
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1 || rvalid === 1'b1 && rready === 1'b1) begin
      e = expq.pop_front();
      if (e[34]) chk(rdata, e[31:0]);
      chk({30'h0, rvalid === 1'b1 ? rresp : bresp}, {30'h0, e[33:32]});
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    expq.push_back({1'b0, r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk({30'h0, awready, wready}, 32'h3);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r,
                    input logic c, output logic [31:0] q);
    expq.push_back({c, r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    q = rdata;
    chk({31'h0, arready}, 32'h1);
    arvalid <= 1'b0;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Counts high cycles and rising edges of the output pin
  task automatic watch(input int n, input int eh, input int er);
    logic p;
    hi = 0;
    ri = 0;
    p = tout;
    repeat (n) begin
      @(posedge aclk);
      hi += int'(tout);
      ri += int'(tout & ~p);
      p = tout;
    end
    if (eh >= 0) chk(32'(hi), 32'(eh));
    chk(32'(ri), 32'(er));
  endtask

  initial begin
    int p, d;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    void'($urandom(32'hB841));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0, RESP_OKAY, 1'b1, v);
    rd(12'h014, 32'h0, RESP_SLVERR, 1'b1, v);
    wr(12'h014, 32'hFFFF, RESP_SLVERR);
    wr(OFS_COUNT, 32'h55, RESP_OKAY);
    rd(OFS_COUNT, 32'h0, RESP_OKAY, 1'b1, v);
    wr(OFS_PERIOD, 32'hFFFF, RESP_OKAY);
    rd(OFS_PERIOD, 32'h3FF, RESP_OKAY, 1'b1, v);
    wstrb <= 4'h1;
    wr(OFS_PERIOD, 32'h0, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_PERIOD, 32'h300, RESP_OKAY, 1'b1, v);
    $display("test registers done");
    p = 8 + $urandom % 32;
    d = 1 + $urandom % (p - 1);
    wr(OFS_PERIOD, 32'(p), RESP_OKAY);
    wr(OFS_DUTY, 32'(d), RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, {23'h0, 1'b1, SEL_WAVE, i < 3 ? PIN_PWM : 2'(i - 3), i == 0, i == 2,
        1'($urandom), 1'b0}, RESP_OKAY);
      if (i == 3) wr(OFS_FLAGS, 32'h3, RESP_OKAY);
      repeat (p + 3) @(posedge aclk);
      watch(2 * p, i == 1 ? 2 * (p - d) : i == 3 ? 0 : i == 4 ? 2 * p : 2 * d,
        i < 3 ? 2 : 0);
    end
    rd(OFS_FLAGS, 32'h3, RESP_OKAY, 1'b1, v);
    chk({30'h0, pflag, dflag}, 32'h3);
    wr(OFS_CTRL, 32'h1A8, RESP_OKAY);
    wr(OFS_DUTY, 32'(p + $urandom % 4), RESP_OKAY);
    repeat (p + 3) @(posedge aclk);
    watch(2 * p, 2 * p, 0);
    wr(OFS_PERIOD, 32'h0, RESP_OKAY);
    wr(OFS_DUTY, 32'h12C, RESP_OKAY);
    repeat (1030) @(posedge aclk);
    watch(2048, 600, 2);
    $display("test pwm done");
    d = 6 + $urandom % 20;
    wr(OFS_PERIOD, 32'h2, RESP_OKAY);
    wr(OFS_DUTY, 32'(d), RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 32'hBA, RESP_OKAY);
      wr(OFS_FLAGS, 32'h3, RESP_OKAY);
      repeat (3) @(posedge aclk);
      fork
        watch(2 * d + 20, -1, 1);
        begin
          if (i < 2) u_pins.set_pin(1'b1, 1'b1);
          else wr(OFS_CTRL, 32'h1BA, RESP_OKAY);
          u_pins.set_pin(1'b1, 1'b0);
        end
      join
      chk(32'(hi >= d && hi <= d + 2), 32'h1);
      rd(OFS_CTRL, 32'hBA, RESP_OKAY, 1'b1, v);
      rd(OFS_FLAGS, 32'h1, RESP_OKAY, 1'b1, v);
      chk({30'h0, pflag, dflag}, 32'h1);
    end
    wr(OFS_DUTY, 32'h3E8, RESP_OKAY);
    wr(OFS_CTRL, 32'h1BA, RESP_OKAY);
    repeat (5) @(posedge aclk);
    wr(OFS_CTRL, 32'hBA, RESP_OKAY);
    repeat (3) @(posedge aclk);
    watch(20, 0, 0);
    $display("test pulse done");
    wr(OFS_PERIOD, 32'h0, RESP_OKAY);
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) begin
        wr(OFS_CTRL, {23'h0, 1'b1, SEL_CAPTURE, 2'(k), 3'h7, s == 1}, RESP_OKAY);
        wr(OFS_FLAGS, 32'h3, RESP_OKAY);
        u_pins.set_pin(s == 0, 1'b1);
        u_pins.set_pin(s == 0, 1'b0);
        rd(OFS_COUNT, 32'h0, RESP_OKAY, 1'b0, v);
        u_pins.set_pin(s == 1, 1'b1);
        repeat (3) @(posedge aclk);
        rd(OFS_FLAGS, {31'h0, k == 0 || k == 2}, RESP_OKAY, 1'b1, v2);
        rd(OFS_DUTY, 32'h0, RESP_OKAY, 1'b0, v2);
        if (k == 0) chk(32'(v2 > v && v2 < v + 40), 32'h1);
        wr(OFS_FLAGS, 32'h3, RESP_OKAY);
        u_pins.set_pin(s == 1, 1'b0);
        repeat (3) @(posedge aclk);
        rd(OFS_FLAGS, {31'h0, k == 1 || k == 2}, RESP_OKAY, 1'b1, v2);
        chk({31'h0, tout}, 32'h0);
      end
    end
    wr(OFS_PERIOD, 32'h8, RESP_OKAY);
    wr(OFS_CTRL, 32'h7F, RESP_OKAY);
    wr(OFS_CTRL, 32'h17F, RESP_OKAY);
    wr(OFS_FLAGS, 32'h3, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(OFS_FLAGS, 32'h2, RESP_OKAY, 1'b1, v);
    rd(OFS_COUNT, 32'h0, RESP_OKAY, 1'b0, v);
    chk(32'(v < 8), 32'h1);
    $display("test capture done");
    give_verdict();
  end
endmodule
`default_nettype wire
